// file: pkg/fpg_pkg.sv
// Purpose: shared constants and types for the flash protection access gate
// Assumes: single clock core_clk at 10 MHz, asynchronous active-high reset
// Notes: protection state is held in a nonvolatile cell outside this logic
//
// Notes on behaviour
// - above 24 and up to 48 MHz system clock each flash access takes one wait state.
// - at or below 24 MHz system clock a flash access takes no wait state.
// - the state leaves manufacturing as open, which restricts nothing.
// - a user request may move the protection state from open to protected.
// - in the protected state every access from the debug port is refused.
// - protected returns to open only after a full erase, done beforehand or in the cycle of the request.
// - a user request may move the protection state from open to kill.
// - in the kill state every kind of debug access is rejected.
// - in the kill state any erase request from outside the chip is ignored.
// - the kill state is permanent; no request, erase or reset leaves it.
// - each flash row has its own write-block and read-block settings.
// - system-call accesses may always read, write and erase flash.
package fpg_pkg;

  typedef enum logic [2:0] {
    FPG_OPEN = 3'b001,
    FPG_PROT = 3'b010,
    FPG_KILL = 3'b100
  } fpg_prot_t;

  // request codes for protection changes
  localparam logic [1:0] FPG_REQ_OPEN = 2'h0;
  localparam logic [1:0] FPG_REQ_PROT = 2'h1;
  localparam logic [1:0] FPG_REQ_KILL = 2'h2;

  // clock thresholds in MHz
  localparam int FPG_ZERO_WS_MHZ = 24;
  localparam int FPG_ONE_WS_MHZ = 48;
  localparam logic [7:0] FPG_ZERO_WS_LIM = 8'(FPG_ZERO_WS_MHZ);
  localparam logic [7:0] FPG_ONE_WS_LIM = 8'(FPG_ONE_WS_MHZ);

  // factory value of the nonvolatile state
  localparam fpg_prot_t FPG_FACTORY_STATE = FPG_OPEN;

  // access sources
  localparam logic [1:0] FPG_SRC_SYSCALL = 2'h0;
  localparam logic [1:0] FPG_SRC_CPU = 2'h1;
  localparam logic [1:0] FPG_SRC_DEBUG = 2'h2;
  localparam logic [1:0] FPG_SRC_EXT = 2'h3;

endpackage : fpg_pkg

// file: src/fpg_wait_ctl.sv
// Purpose: wait-state insertion for flash accesses
// Assumes: sysclk_mhz is steady during an access
// Notes: one registered ready pulse per accepted access
`timescale 1ns/100ps
module fpg_wait_ctl (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] sysclk_mhz,
  input wire logic start,
  output logic done
);

  typedef struct packed {
    logic busy;
    logic done;
  } fpg_ws_t;

  fpg_ws_t st_ff;
  fpg_ws_t nxt_st;
  logic zero_ws;

  // above 48 MHz is out of range; treat it as one wait state anyway
  assign zero_ws = (sysclk_mhz <= fpg_pkg::FPG_ZERO_WS_LIM);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (st_ff.busy) begin
      nxt_st.busy = 1'b0;
      nxt_st.done = 1'b1;
    end else if (start) begin
      if (zero_ws) begin
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.busy = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;

endmodule : fpg_wait_ctl

// file: src/fpg_gate.sv
// Purpose: flash protection state keeper and access gate
// Assumes: nv_state_in reflects the nonvolatile cell and is valid at reset
// Notes: nv_wr pulses ask the nonvolatile cell to store nv_state_out
`timescale 1ns/100ps
module fpg_gate #(
  parameter int ROWS = 128,
  parameter int ROW_W = 7
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] sysclk_mhz,
  input wire logic [2:0] nv_state_in,
  output logic nv_wr,
  output logic [2:0] nv_state_out,
  output logic [2:0] prot_state,
  input wire logic chg_req,
  input wire logic [1:0] chg_code,
  output logic chg_ack,
  output logic chg_rej,
  input wire logic erase_all_done,
  input wire logic row_cfg_we,
  input wire logic [ROW_W-1:0] row_cfg_row,
  input wire logic row_cfg_wblk,
  input wire logic row_cfg_rblk,
  input wire logic acc_req,
  input wire logic [1:0] acc_src,
  input wire logic acc_wr,
  input wire logic acc_erase,
  input wire logic [ROW_W-1:0] acc_row,
  output logic acc_done,
  output logic acc_deny,
  output logic flash_go
);

  typedef struct packed {
    logic loaded;
    logic [2:0] state;
    logic erased;
    logic nv_wr;
    logic chg_ack;
    logic chg_rej;
    logic deny;
    logic go;
    logic pend;
    logic [ROWS-1:0] wblk;
    logic [ROWS-1:0] rblk;
  } fpg_st_t;

  fpg_st_t st_ff;
  fpg_st_t nxt_st;
  logic ws_done;

  // decides whether an access may reach the flash array
  function automatic logic fpg_allow(
    input logic [2:0] state,
    input logic [1:0] src,
    input logic wr,
    input logic erase,
    input logic wb,
    input logic rb
  );
    logic ok;
    ok = 1'b1;
    if (src == fpg_pkg::FPG_SRC_SYSCALL) begin
      ok = 1'b1;
    end else if (src == fpg_pkg::FPG_SRC_DEBUG &&
                 state != 3'(fpg_pkg::FPG_OPEN)) begin
      ok = 1'b0;
    end else if (src == fpg_pkg::FPG_SRC_EXT && erase &&
                 state == 3'(fpg_pkg::FPG_KILL)) begin
      ok = 1'b0;
    end else if (src == fpg_pkg::FPG_SRC_EXT &&
                 state == 3'(fpg_pkg::FPG_KILL)) begin
      ok = 1'b0;
    end else if (!erase && wr && wb) begin
      ok = 1'b0;
    end else if (!erase && !wr && rb) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : fpg_allow

  fpg_wait_ctl u_wait (
    .core_clk(core_clk),
    .rst(rst),
    .sysclk_mhz(sysclk_mhz),
    .start(nxt_st.go),
    .done(ws_done)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.nv_wr = 1'b0;
    nxt_st.chg_ack = 1'b0;
    nxt_st.chg_rej = 1'b0;
    nxt_st.deny = 1'b0;
    nxt_st.go = 1'b0;
    // state is taken from the nonvolatile cell after reset, not forced
    if (!st_ff.loaded) begin
      nxt_st.loaded = 1'b1;
      case (nv_state_in)
        3'(fpg_pkg::FPG_PROT): nxt_st.state = 3'(fpg_pkg::FPG_PROT);
        3'(fpg_pkg::FPG_KILL): nxt_st.state = 3'(fpg_pkg::FPG_KILL);
        3'(fpg_pkg::FPG_OPEN): nxt_st.state = 3'(fpg_pkg::FPG_OPEN);
        // a corrupt cell falls to the safe side
        default: nxt_st.state = 3'(fpg_pkg::FPG_KILL);
      endcase
    end else begin
      if (erase_all_done) begin
        nxt_st.erased = 1'b1;
      end
      if (chg_req) begin
        nxt_st.chg_rej = 1'b1;
        case (st_ff.state)
          3'(fpg_pkg::FPG_OPEN): begin
            if (chg_code == fpg_pkg::FPG_REQ_PROT) begin
              nxt_st.state = 3'(fpg_pkg::FPG_PROT);
              nxt_st.chg_rej = 1'b0;
            end else if (chg_code == fpg_pkg::FPG_REQ_KILL) begin
              nxt_st.state = 3'(fpg_pkg::FPG_KILL);
              nxt_st.chg_rej = 1'b0;
            end
          end
          3'(fpg_pkg::FPG_PROT): begin
            if (chg_code == fpg_pkg::FPG_REQ_OPEN &&
                (st_ff.erased || erase_all_done)) begin
              nxt_st.state = 3'(fpg_pkg::FPG_OPEN);
              nxt_st.chg_rej = 1'b0;
            end
          end
          3'(fpg_pkg::FPG_KILL): begin
            nxt_st.chg_rej = 1'b1;
          end
          default: begin
            nxt_st.chg_rej = 1'b1;
          end
        endcase
        if (!nxt_st.chg_rej) begin
          nxt_st.chg_ack = 1'b1;
          nxt_st.nv_wr = 1'b1;
          nxt_st.erased = 1'b0;
        end
      end
      if (row_cfg_we) begin
        nxt_st.wblk[row_cfg_row] = row_cfg_wblk;
        nxt_st.rblk[row_cfg_row] = row_cfg_rblk;
      end
      if (st_ff.pend && ws_done) begin
        nxt_st.pend = 1'b0;
      end
      if (acc_req && !st_ff.pend) begin
        if (fpg_allow(st_ff.state, acc_src, acc_wr, acc_erase,
                      st_ff.wblk[acc_row], st_ff.rblk[acc_row])) begin
          nxt_st.go = 1'b1;
          nxt_st.pend = 1'b1;
        end else begin
          nxt_st.deny = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign nv_wr = st_ff.nv_wr;
  assign nv_state_out = st_ff.state;
  assign prot_state = st_ff.state;
  assign chg_ack = st_ff.chg_ack;
  assign chg_rej = st_ff.chg_rej;
  assign acc_done = ws_done;
  assign acc_deny = st_ff.deny;
  assign flash_go = st_ff.go;

endmodule : fpg_gate

// file: testbench/fpg_nv_model.sv
// Purpose: nonvolatile cell behind the protection gate
// Assumes: a write lands on the clock edge that sees nv_wr
// Notes: has no reset input, so the state outlives every reset
`timescale 1ns/100ps
module fpg_nv_model (
  input wire logic core_clk,
  input wire logic nv_wr,
  input wire logic [2:0] nv_state_out,
  output logic [2:0] nv_state_in
);
  initial nv_state_in = fpg_pkg::FPG_FACTORY_STATE;
  always @(posedge core_clk) begin
    if (nv_wr) nv_state_in <= nv_state_out;
  end
endmodule : fpg_nv_model

// file: testbench/fpg_gate_asserts.sv
// Purpose: timing and gating checks on the gate ports
// Assumes: access requests spaced until done
// Notes: bound to every gate instance
`timescale 1ns/100ps
module fpg_gate_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] sysclk_mhz,
  input wire logic [2:0] prot_state,
  input wire logic nv_wr,
  input wire logic chg_req,
  input wire logic [1:0] chg_code,
  input wire logic chg_ack,
  input wire logic chg_rej,
  input wire logic acc_req,
  input wire logic [1:0] acc_src,
  input wire logic acc_erase,
  input wire logic acc_done,
  input wire logic acc_deny,
  input wire logic flash_go
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_slow;
    !acc_done ##1 acc_done;
  endsequence
  sequence s_dbg;
    acc_req && acc_src == 2'h2;
  endsequence
  a_one_wait: assert property (
    flash_go && sysclk_mhz > 8'h18 |-> s_slow) else $error("no wait state");
  a_zero_wait: assert property (
    flash_go && sysclk_mhz <= 8'h18 |-> acc_done) else $error("extra wait");
  a_dbg_prot: assert property (
    s_dbg ##0 prot_state == 3'h2 |=> acc_deny) else $error("debug let in");
  a_dbg_kill: assert property (
    s_dbg ##0 prot_state == 3'h4 |=> !flash_go) else $error("debug in kill");
  a_ext_erase: assert property (
    acc_req && acc_src == 2'h3 && acc_erase && prot_state == 3'h4
    |=> !flash_go) else $error("external erase in kill");
  a_kill_held: assert property (
    prot_state == 3'h4 |=> $stable(prot_state)) else $error("kill left");
  a_sys_grant: assert property (
    acc_req && acc_src == 2'h0 && prot_state != 3'h0 |=> flash_go)
    else $error("system call refused");
  a_open_prot: assert property (
    chg_req && chg_code == 2'h1 && prot_state == 3'h1
    |=> chg_ack && nv_wr && prot_state == 3'h2) else $error("no protect");
  a_kill_rej: assert property (
    chg_req && prot_state == 3'h4 |=> chg_rej && !chg_ack && !nv_wr)
    else $error("change accepted in kill");
endmodule : fpg_gate_asserts
bind fpg_gate fpg_gate_asserts u_chk (.*);

// file: testbench/tb.sv
// Purpose: self-checking bench for the protection gate
// Assumes: cell model keeps the state through reset
// Notes: expectations come from the model state ms and row maps
`timescale 1ns/100ps
module tb;
  logic core_clk, rst, nv_wr, chg_req, chg_ack, chg_rej, erase_all_done;
  logic row_cfg_we, row_cfg_wblk, row_cfg_rblk, acc_req, acc_wr, acc_erase;
  logic acc_done, acc_deny, flash_go;
  logic [7:0] sysclk_mhz;
  logic [2:0] nv_state_in, nv_state_out, prot_state;
  logic [1:0] chg_code, acc_src;
  logic [6:0] row_cfg_row, acc_row;
  logic wbm [128];
  logic rbm [128];
  int errors, checks, cyc, ms;
  fpg_gate dut (.*);
  fpg_nv_model u_nv (.*);
  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  // run needs a few hundred cycles; the margin is generous
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      wrap_up;
    end
  end
  task automatic chk(logic [2:0] seen, logic [2:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %b want %b", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic do_reset(int n);
    rst = 1;
    repeat (n) @(negedge core_clk);
    rst = 0;
    wbm = '{default: 0};
    rbm = '{default: 0};
    repeat (2) @(negedge core_clk);
    chk(prot_state, 3'(ms));
  endtask : do_reset
  task automatic rowcfg(logic [6:0] r, logic w, logic rd);
    {row_cfg_we, row_cfg_wblk, row_cfg_rblk} = {1'b1, w, rd};
    row_cfg_row = r;
    wbm[r] = w;
    rbm[r] = rd;
    @(negedge core_clk);
    row_cfg_we = 0;
    @(negedge core_clk);
  endtask : rowcfg
  task automatic chg(logic [1:0] c, logic er);
    logic ok;
    ok = (ms == 1 && (c == 1 || c == 2)) || (ms == 2 && c == 0 && er);
    {chg_req, chg_code, erase_all_done} = {1'b1, c, er};
    @(negedge core_clk);
    if (ok) ms = (c == 0) ? 1 : (c == 1) ? 2 : 4;
    chk({chg_ack, chg_rej, nv_wr}, {ok, !ok, ok});
    chk(prot_state, 3'(ms));
    chk(nv_state_out, 3'(ms));
    // one idle edge keeps the request from being lowered and raised at once
    {chg_req, erase_all_done} = 2'h0;
    @(negedge core_clk);
    chk({chg_ack, chg_rej, nv_wr}, 3'h0);
    chk(nv_state_in, 3'(ms));
  endtask : chg
  task automatic acc(logic [1:0] s, logic w, logic e, logic [6:0] r);
    logic go;
    logic fast;
    go = s == 0 || !((s == 2 && ms != 1) || (s == 3 && ms == 4)
         || (!e && (w ? wbm[r] : rbm[r])));
    sysclk_mhz = 8'(1 + $urandom % 48);
    fast = sysclk_mhz <= 8'h18;
    {acc_req, acc_src, acc_wr, acc_erase, acc_row} = {1'b1, s, w, e, r};
    @(negedge core_clk);
    acc_req = 0;
    chk({flash_go, acc_deny, acc_done}, {go, !go, go & fast});
    @(negedge core_clk);
    chk({flash_go, acc_deny, acc_done}, {2'b00, go & !fast});
    // pending clears one edge after done; the next request waits for it
    @(negedge core_clk);
    chk({flash_go, acc_deny, acc_done}, 3'h0);
  endtask : acc
  // every source with read, write and erase; rows lean on the blocked ones
  task automatic sweep;
    for (int k = 0; k < 12; k++)
      acc(2'(k / 3), k % 3 == 1, k % 3 == 2,
          ($urandom % 4 == 0) ? 7'($urandom) : 7'(5 + $urandom % 2));
  endtask : sweep
  initial begin
    void'($urandom(32'hb706_bf86));
    {chg_req, chg_code, erase_all_done, row_cfg_we, row_cfg_wblk} = '0;
    {row_cfg_rblk, acc_req, acc_src, acc_wr, acc_erase} = '0;
    {row_cfg_row, acc_row, sysclk_mhz} = '0;
    ms = 1;
    rst = 1;
    do_reset(8);
    sweep;
    rowcfg(7'h05, 1, 0);
    rowcfg(7'h06, 0, 1);
    sweep;
    chg(2'h0, 0);
    chg(2'h1, 0);
    sweep;
    chg(2'h2, 0);
    chg(2'h0, 0);
    chg(2'h0, 1);
    chg(2'h2, 0);
    sweep;
    do_reset(3);
    chg(2'h0, 1);
    chg(2'h1, 0);
    sweep;
    wrap_up;
  end
endmodule : tb
